// File: logic/acc_add_and_ops.sv
// Add and conjunction datapath slice of the core
`timescale 1ns/1ps
`include "alu_defs.svh"
// Notes on behaviour
// RULE1 - sum_to_memory adds memory byte and work_register
// RULE2 - Sum written to memory; four flags updated
// RULE3 - conj_mem_to_work ANDs work_register with memory
// RULE4 - conj_imm_to_work ANDs work_register with immediate
// RULE5 - AND forms write work_register, zero flag only
// RULE6 - conj_to_memory ANDs memory byte with work_register
// RULE7 - conj_to_memory writes memory, zero flag, keeps work
module acc_add_and_ops
    import alu_pkg::*;
#(
    parameter int W = `DATA_W
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          arst_n,
    // Decoder request
    input  wire logic          op_valid,
    input  alu_pkg::op_t       op,
    input  wire logic [W-1:0]  imm_data,
    // Data memory read port
    input  wire logic [W-1:0]  mem_rdata,
    // Data memory write-back
    output logic               mem_we_ff,
    output logic [W-1:0]       mem_wdata_ff,
    // Work register
    output logic [W-1:0]       work_register_ff,
    // Flag updates to status register
    output logic               flag_upd_ff,
    output logic               sign_wrap_upd_ff,
    output logic               carry_upd_ff,
    output logic               sign_wrap_flag_ff,
    output logic               result_null_flag_ff,
    output logic               half_carry_flag_ff,
    output logic               ninth_bit_out_flag_ff
);
    import alu_pkg::*;

    // ------------------------------------------------------------
    // Op decoding for the request strobes and zero test; result select decodes op itself
    // ------------------------------------------------------------
    // Ops whose result lands in data memory
    function automatic logic op_writes_mem(op_t code);
        return (code == OP_SUM_TO_MEMORY)
            || (code == OP_CONJ_TO_MEMORY);
    endfunction

    // Ops whose result lands in the work register
    function automatic logic op_writes_work(op_t code);
        return (code == OP_CONJ_MEM_TO_WORK)
            || (code == OP_CONJ_IMM_TO_WORK);
    endfunction

    // Only the add touches the carry-type flags
    function automatic logic op_is_add(op_t code);
        return code == OP_SUM_TO_MEMORY;
    endfunction

    // Zero test shared by every result path
    function automatic logic byte_is_null(logic [W-1:0] value);
        return value == `ZERO_BYTE;
    endfunction

    // ------------------------------------------------------------
    // Datapath signals
    // ------------------------------------------------------------
    // Adder outputs
    logic [W-1:0] add_sum;
    logic         add_c;
    logic         add_hc;
    logic         add_ov;
    // Conjunction operand and result
    logic [W-1:0] conj_other;
    logic [W-1:0] conj_bits;
    // Request decode and selected result
    logic [W-1:0] nxt_result;
    logic         is_sum;
    logic         is_to_mem;
    logic         is_to_work;
    // Next values of strobes and zero flag
    logic         nxt_mem_we;
    logic         nxt_flag_upd;
    logic         nxt_add_upd;
    logic         nxt_null;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    // A request without op_valid changes nothing
    always_comb begin
        is_sum     = op_valid && op_is_add(op);
        is_to_mem  = op_valid && op_writes_mem(op);
        is_to_work = op_valid && op_writes_work(op);
    end

    // ------------------------------------------------------------
    // Adder; reads the work register as it stands
    // ------------------------------------------------------------
    alu_adder #(.W(W)) u_adder (
        .a          (work_register_ff),
        .b          (mem_rdata),
        .sum        (add_sum),          // see RULE1
        .carry      (add_c),
        .half_carry (add_hc),
        .sign_wrap  (add_ov)
    );

    // ------------------------------------------------------------
    // Bitwise conjunction, one gate per bit
    // ------------------------------------------------------------
    // Immediate replaces the memory byte for one form only
    assign conj_other = (op == OP_CONJ_IMM_TO_WORK) ? imm_data
                                                     : mem_rdata;

    for (genvar g = 0; g < W; g++) begin : g_conj
        assign conj_bits[g] = work_register_ff[g] & conj_other[g];
    end

    // ------------------------------------------------------------
    // Result select
    // ------------------------------------------------------------
    always_comb begin
        unique case (op)
            OP_SUM_TO_MEMORY: begin
                nxt_result = add_sum; // see RULE1
            end
            OP_CONJ_MEM_TO_WORK: begin
                nxt_result = conj_bits; // see RULE3
            end
            OP_CONJ_IMM_TO_WORK: begin
                nxt_result = conj_bits; // see RULE4
            end
            OP_CONJ_TO_MEMORY: begin
                nxt_result = conj_bits; // see RULE6
            end
            // Idle code and unused encodings
            default: begin
                nxt_result = `ZERO_BYTE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next values of strobes and zero flag
    // ------------------------------------------------------------
    always_comb begin
        nxt_mem_we   = is_to_mem;
        nxt_flag_upd = is_to_mem || is_to_work;
        nxt_add_upd  = is_sum;
        nxt_null     = byte_is_null(nxt_result);
    end

    // ------------------------------------------------------------
    // Work register
    // ------------------------------------------------------------
    // Loaded only by the two work-register conjunction forms; the add and
    // the memory conjunction read it and leave it alone
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            work_register_ff <= `WORK_RST;
        end else if (is_to_work) begin
            work_register_ff <= nxt_result; // see RULE5
        end
    end

    // ------------------------------------------------------------
    // Memory write strobe, one cycle per request that writes memory
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mem_we_ff <= 1'b0;
        end else begin
            mem_we_ff <= nxt_mem_we; // see RULE2 see RULE7
        end
    end

    // ------------------------------------------------------------
    // Memory write data; holds between writes
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mem_wdata_ff <= `ZERO_BYTE;
        end else if (is_to_mem) begin
            mem_wdata_ff <= nxt_result; // see RULE2
        end
    end

    // ------------------------------------------------------------
    // Flag update strobes: flag_upd_ff one cycle per accepted op, sign-wrap and carry strobes for the add only
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            flag_upd_ff      <= 1'b0;
            sign_wrap_upd_ff <= 1'b0;
            carry_upd_ff     <= 1'b0;
        end else begin
            flag_upd_ff      <= nxt_flag_upd; // see RULE5
            sign_wrap_upd_ff <= nxt_add_upd; // see RULE2
            carry_upd_ff     <= nxt_add_upd;
        end
    end

    // ------------------------------------------------------------
    // Zero flag, follows every accepted op
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            result_null_flag_ff <= 1'b0;
        end else if (nxt_flag_upd) begin
            result_null_flag_ff <= nxt_null; // see RULE5
        end
    end

    // ------------------------------------------------------------
    // Add-only flags; they hold across the conjunction forms
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sign_wrap_flag_ff     <= 1'b0;
            half_carry_flag_ff    <= 1'b0;
            ninth_bit_out_flag_ff <= 1'b0;
        end else if (is_sum) begin
            sign_wrap_flag_ff     <= add_ov; // see RULE2
            half_carry_flag_ff    <= add_hc;
            ninth_bit_out_flag_ff <= add_c;
        end
    end
endmodule

// File: logic/alu_defs.svh
// Constants for the add and conjunction datapath slice
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH
`define DATA_W        8
`define HALF_W        4
`define SIGN_BIT      7
`define ZERO_BYTE     8'h00
`define WORK_RST      8'h00
`endif

// File: logic/alu_pkg.sv
// Types for the add and conjunction datapath slice
package alu_pkg;
    typedef enum logic [2:0] {
        OP_NONE,
        OP_SUM_TO_MEMORY,
        OP_CONJ_MEM_TO_WORK,
        OP_CONJ_IMM_TO_WORK,
        OP_CONJ_TO_MEMORY
    } op_t;
endpackage

// File: logic/alu_adder.sv
// Eight-bit adder with half carry and signed overflow
`timescale 1ns/1ps
`include "alu_defs.svh"
module alu_adder #(
    parameter int W = `DATA_W
) (
    // Operands
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    // Results
    output logic [W-1:0]      sum,
    output logic              carry,
    output logic              half_carry,
    output logic              sign_wrap
);
    logic [`HALF_W:0] low_sum;
    logic [W:0]       full_sum;

    always_comb begin
        low_sum    = {1'b0, a[`HALF_W-1:0]} + {1'b0, b[`HALF_W-1:0]};
        full_sum   = {1'b0, a} + {1'b0, b};
        sum        = full_sum[W-1:0];
        carry      = full_sum[W];
        half_carry = low_sum[`HALF_W];
        // Same-sign operands giving a result of the other sign
        sign_wrap  = (a[W-1] == b[W-1]) && (sum[W-1] != a[W-1]);
    end
endmodule

// File: testbench/acc_ops_chk_sva.sv
// Port checker for the add and conjunction datapath
`timescale 1ns/1ps
module acc_ops_chk (
    input wire logic       clk_sys, arst_n, op_valid, mem_we_ff,
    input wire logic       flag_upd_ff, carry_upd_ff,
    input alu_pkg::op_t    op,
    input wire logic [7:0] imm_data, mem_rdata, mem_wdata_ff,
    input wire logic [7:0] work_register_ff
);
    import alu_pkg::*;
    wire logic [7:0] m = mem_rdata;
    wire logic [7:0] w = work_register_ff;
    wire logic ad = op_valid && op == OP_SUM_TO_MEMORY;
    wire logic am = op_valid && op == OP_CONJ_MEM_TO_WORK;
    wire logic ai = op_valid && op == OP_CONJ_IMM_TO_WORK;
    wire logic tm = op_valid && op == OP_CONJ_TO_MEMORY;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    property p_sum; ad |=> mem_wdata_ff == $past(m) + $past(w); endproperty
    a_sum: assert property (p_sum) else $error("sum");
    property p_sfl;
        ad |=> mem_we_ff && carry_upd_ff && flag_upd_ff;
    endproperty
    a_sfl: assert property (p_sfl) else $error("add strobes");
    property p_am; am |=> w == ($past(w) & $past(m)); endproperty
    a_am: assert property (p_am) else $error("and mem");
    property p_ai; ai |=> w == ($past(w) & $past(imm_data)); endproperty
    a_ai: assert property (p_ai) else $error("and imm");
    property p_aw;
        am || ai |=> flag_upd_ff && !mem_we_ff && !carry_upd_ff;
    endproperty
    a_aw: assert property (p_aw) else $error("and strobes");
    property p_tm; tm |=> mem_wdata_ff == ($past(m) & $past(w)); endproperty
    a_tm: assert property (p_tm) else $error("and to mem");
    property p_tk; tm |=> mem_we_ff && $stable(w) && !carry_upd_ff; endproperty
    a_tk: assert property (p_tk) else $error("work kept");
endmodule

// File: testbench/data_mem_model.sv
// Behavioural data memory on the far side of the datapath
`timescale 1ns/1ps
module data_mem_model (
    input wire logic       clk_sys,
    input wire logic [3:0] addr,
    input wire logic       mem_we_ff,
    input wire logic [7:0] mem_wdata_ff,
    output logic [7:0]     mem_rdata
);
    logic [7:0] mem [16];
    logic [3:0] addr_ff;
    initial for (int k = 0; k < 16; k++) mem[k] = 8'(k * 8'h47 + 8'h81);
    // Write strobe lags the request by one edge
    always @(posedge clk_sys) begin
        addr_ff <= addr;
        if (mem_we_ff) mem[addr_ff] <= mem_wdata_ff;
    end
    assign mem_rdata = mem[addr];
endmodule

// File: testbench/tb.sv
// Self-checking bench for the add and conjunction datapath
`timescale 1ns/1ps
module tb;
    import alu_pkg::*;
    logic clk_sys = 0, arst_n = 0, op_valid = 0, mem_we_ff, flag_upd_ff;
    logic sign_wrap_upd_ff, carry_upd_ff, sign_wrap_flag_ff;
    logic result_null_flag_ff, half_carry_flag_ff, ninth_bit_out_flag_ff;
    logic [7:0] imm_data = 8'h00, mem_rdata, mem_wdata_ff, work_register_ff;
    logic [7:0] ew = 8'h00, ed = 8'h00;
    logic [3:0] addr = 4'h0;
    logic [10:0] r;
    logic ewe = 0, efu = 0, ecu = 0, ez = 0, ec = 0, eh = 0, ev = 0;
    op_t op = OP_NONE;
    int n_errors = 0, comparisons = 0;
    acc_add_and_ops u_dut (.*);
    data_mem_model u_mem (.*);
    function automatic logic [10:0] add_of(logic [7:0] a, b);
        logic [8:0] s;
        s = a + b;
        return {s[8], {1'b0, a[3:0]} + b[3:0] > 5'h0F,
                a[7] == b[7] && s[7] != a[7], s[7:0]};
    endfunction
    task automatic chk(string s, logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", s, e, g);
        end
    endtask
    task automatic test_done;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial forever #2 clk_sys = ~clk_sys;
    initial begin
        repeat (2000) @(posedge clk_sys);
        n_errors++;
        test_done;
    end
    initial begin
        void'($urandom(86));
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(posedge clk_sys);
            op_valid <= i % 7 != 3;
            op <= op_t'($urandom_range(4));
            imm_data <= 8'($urandom);
            addr <= 4'($urandom);
            @(negedge clk_sys);
            chk("mem data", ed, mem_wdata_ff);
            chk("work", ew, work_register_ff);
            chk("flags", {ewe, efu, ecu, ecu, ez, ev, eh, ec},
                {mem_we_ff, flag_upd_ff, sign_wrap_upd_ff, carry_upd_ff,
                 result_null_flag_ff, sign_wrap_flag_ff,
                 half_carry_flag_ff, ninth_bit_out_flag_ff});
            r = add_of(ew, mem_rdata);
            {ewe, efu, ecu} = 3'h0;
            if (op_valid) case (op)
                OP_SUM_TO_MEMORY: begin
                    {ec, eh, ev, ed} = r;
                    {ewe, efu, ecu} = 3'h7;
                    ez = ed == 8'h00;
                end
                OP_CONJ_TO_MEMORY: begin
                    ed = ew & mem_rdata;
                    {ewe, efu} = 2'h3;
                    ez = ed == 8'h00;
                end
                OP_CONJ_MEM_TO_WORK, OP_CONJ_IMM_TO_WORK: begin
                    ew &= op == OP_CONJ_IMM_TO_WORK ? imm_data : mem_rdata;
                    efu = 1'b1;
                    ez = ew == 8'h00;
                end
                default: ;
            endcase
        end
        test_done;
    end
endmodule
bind acc_add_and_ops acc_ops_chk u_chk (.*);
